// [ref_clock_pkg.sv]
// constants shared by the reference clock output selection block
package ref_clock_pkg;

    // ********************
    // clock and frequency plan
    // ********************
    localparam longint CLK_FREQ_HZ     = 125000000;
    localparam int     CLK_FREQ_KHZ    = 125000;
    localparam longint FREQ_8K_HZ      = 8000;
    localparam longint FREQ_64K_HZ     = 64000;
    localparam longint FREQ_T1_HZ      = 1544000;
    localparam longint FREQ_E1_HZ      = 2048000;
    localparam longint FREQ_4096K_HZ   = 4096000;
    localparam longint FREQ_8192K_HZ   = 8192000;
    localparam longint FREQ_19440K_HZ  = 19440000;
    localparam longint FREQ_32768K_HZ  = 32768000;
    localparam int     T1_RATE_KHZ     = 1544;
    localparam int     E1_RATE_KHZ     = 2048;

    // phase step of a 32-bit accumulator advanced once per clk
    function automatic logic [31:0] nco_step(input longint hz);
        nco_step = 32'((hz << 32) / CLK_FREQ_HZ);
    endfunction

    localparam logic [31:0] STEP_8K     = nco_step(FREQ_8K_HZ);
    localparam logic [31:0] STEP_64K    = nco_step(FREQ_64K_HZ);
    localparam logic [31:0] STEP_T1     = nco_step(FREQ_T1_HZ);
    localparam logic [31:0] STEP_E1     = nco_step(FREQ_E1_HZ);
    localparam logic [31:0] STEP_4096K  = nco_step(FREQ_4096K_HZ);
    localparam logic [31:0] STEP_8192K  = nco_step(FREQ_8192K_HZ);
    localparam logic [31:0] STEP_19440K = nco_step(FREQ_19440K_HZ);
    localparam logic [31:0] STEP_32768K = nco_step(FREQ_32768K_HZ);

    // ********************
    // external input loss: more than eight periods without an edge
    // ********************
    localparam int         LOSS_PERIODS   = 8;
    localparam int         LOSS_CNT_W     = 10;
    localparam logic [9:0] LOSS_CYCLES_T1 =
        10'((LOSS_PERIODS * CLK_FREQ_KHZ + T1_RATE_KHZ - 1) / T1_RATE_KHZ);
    localparam logic [9:0] LOSS_CYCLES_E1 =
        10'((LOSS_PERIODS * CLK_FREQ_KHZ + E1_RATE_KHZ - 1) / E1_RATE_KHZ);

    // ********************
    // register map
    // ********************
    localparam logic [2:0] ADDR_GEN_CFG    = 3'h0;
    localparam logic [2:0] ADDR_REF_A      = 3'h1;
    localparam logic [2:0] ADDR_REF_B      = 3'h2;
    localparam logic [2:0] ADDR_REF_CFG    = 3'h3;
    localparam logic [2:0] ADDR_STATUS     = 3'h4;
    localparam logic [2:0] ADDR_STRAPS     = 3'h5;

    localparam logic [7:0] GEN_CFG_MASK    = 8'h0f;
    localparam logic [7:0] REF_SEL_MASK    = 8'h7f;
    localparam logic [7:0] REF_CFG_MASK    = 8'h7f;
    localparam logic [7:0] GEN_CFG_RESET   = 8'h00;
    localparam logic [7:0] REF_SEL_RESET   = 8'h00;
    localparam logic [7:0] REF_CFG_RESET   = 8'h10;

    localparam int BIT_T1_RATE     = 0;
    localparam int BIT_T1_EN       = 1;
    localparam int BIT_E1_RATE     = 2;
    localparam int BIT_E1_EN       = 3;
    localparam int BIT_EXT_RATE    = 5;
    localparam int BIT_REF_EN      = 6;
    localparam int BIT_FREE_RUN    = 3;
    localparam int BIT_SYNTH_BYP   = 4;
    localparam int BIT_HOLD_HIGH   = 5;
    localparam int BIT_TAP_SELECT  = 6;

    // ********************
    // source select and synthesizer codes
    // ********************
    localparam int         CHANNELS       = 17;
    localparam logic [4:0] SEL_EXT_FIRST  = 5'h1d;
    localparam logic [2:0] SYN_8K         = 3'h0;
    localparam logic [2:0] SYN_2048K      = 3'h1;
    localparam logic [2:0] SYN_4096K      = 3'h2;
    localparam logic [2:0] SYN_64K        = 3'h3;
    localparam logic [2:0] SYN_8192K      = 3'h4;
    localparam logic [2:0] SYN_19440K     = 3'h5;
    localparam logic [2:0] SYN_32768K     = 3'h6;

    // synchroniser needs four edges, so capture runs six to see settled straps
    localparam logic [2:0] STRAP_SETTLE   = 3'h6;

endpackage

// [pin_sync.sv]
// three-stage synchroniser for pins arriving from outside the clk domain
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule

// [ref_clock_output_select.sv]
// reference and free-running clock output selection with register port
//
// Overview of operation
// RQ1 - T1 free output: off, 8 kHz, line rate
// RQ2 - E1 free output: off, 8 kHz, line rate
// RQ3 - free outputs come from internal generator
// RQ4 - straps give master rate N times base
// RQ5 - each reference output has own enable
// RQ6 - five-bit select picks one of 17 channels
// RQ7 - recovered rate follows selected channel line mode
// RQ8 - tap bit picks before or after attenuator
// RQ9 - output A synthesizer, seven selectable frequencies
// RQ10 - free-run: synthesizer rate locked to master
// RQ11 - select 11101 to 11111 picks external input
// RQ12 - software sets external rate bit to match
// RQ13 - external input passes through unless synthesized
// RQ14 - free-run codes 000 and 011 unused
// RQ15 - line loss: hold high or master-locked
// RQ16 - external input silent eight periods is lost
// RQ17 - source changes never make short pulses; the code holds setting-word changes only (B's omits the hold-high bit), not loss switches
`timescale 1ns/100ps
module ref_clock_output_select (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [3:0]  master_rate_straps,
    input  wire logic [16:0] recovered_clock_raw,
    input  wire logic [16:0] recovered_clock_filtered,
    input  wire logic [16:0] channel_e1_mode,
    input  wire logic [16:0] line_signal_loss,
    input  wire logic        external_clock_in_a,
    input  wire logic        external_clock_in_b,
    output logic             t1_free_clock_out,
    output logic             t1_free_clock_oe,
    output logic             e1_free_clock_out,
    output logic             e1_free_clock_oe,
    output logic             ref_clock_out_a,
    output logic             ref_clock_out_a_oe,
    output logic             ref_clock_out_b,
    output logic             ref_clock_out_b_oe,
    output logic      [2:0]  generator_multiplier,
    output logic             generator_e1_family
);

    // ********************
    // software registers
    // ********************
    logic [7:0] free_clock_gen_config_reg;
    logic [7:0] ref_a_select_reg;
    logic [7:0] ref_b_select_reg;
    logic [7:0] ref_clock_config_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            free_clock_gen_config_reg <= ref_clock_pkg::GEN_CFG_RESET;
        end else if (reg_wr && reg_addr == ref_clock_pkg::ADDR_GEN_CFG) begin
            free_clock_gen_config_reg <= reg_wdata & ref_clock_pkg::GEN_CFG_MASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_a_select_reg <= ref_clock_pkg::REF_SEL_RESET;
            ref_b_select_reg <= ref_clock_pkg::REF_SEL_RESET;
        end else if (reg_wr && reg_addr == ref_clock_pkg::ADDR_REF_A) begin
            ref_a_select_reg <= reg_wdata & ref_clock_pkg::REF_SEL_MASK;
        end else if (reg_wr && reg_addr == ref_clock_pkg::ADDR_REF_B) begin
            ref_b_select_reg <= reg_wdata & ref_clock_pkg::REF_SEL_MASK;
        end
    end

    // synthesizer starts bypassed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_clock_config_reg <= ref_clock_pkg::REF_CFG_RESET;
        end else if (reg_wr && reg_addr == ref_clock_pkg::ADDR_REF_CFG) begin
            ref_clock_config_reg <= reg_wdata & ref_clock_pkg::REF_CFG_MASK;
        end
    end

    // ********************
    // pin synchronisers
    // ********************
    logic [35:0] clocks_sync;
    logic [3:0]  straps_sync;

    pin_sync #(.WIDTH(36)) clock_pins (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    ({external_clock_in_b, external_clock_in_a,
                     recovered_clock_filtered, recovered_clock_raw}),
        .level_out (clocks_sync)
    );

    pin_sync #(.WIDTH(4)) strap_pins (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (master_rate_straps),
        .level_out (straps_sync)
    );

    logic [16:0] raw_sync;
    logic [16:0] filtered_sync;
    logic [1:0]  ext_sync;

    assign raw_sync      = clocks_sync[16:0];
    assign filtered_sync = clocks_sync[33:17];
    assign ext_sync      = clocks_sync[35:34];

    // ********************
    // master rate straps
    // ********************
    logic [2:0] strap_wait_reg;

    // RQ4 strap capture scaling
    // straps are loaded on each of the first six cycles after reset and then held, so the kept value is from the settled synchroniser
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_wait_reg       <= 3'h0;
            generator_multiplier <= 3'h0;
            generator_e1_family  <= 1'b0;
        end else if (strap_wait_reg != ref_clock_pkg::STRAP_SETTLE) begin
            strap_wait_reg       <= strap_wait_reg + 3'h1;
            generator_multiplier <= straps_sync[2:0];
            generator_e1_family  <= straps_sync[3];
        end
    end

    // ********************
    // source decode
    // ********************
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic       ext_a_sel;
    logic       ext_b_sel;
    logic       chan_a_ok;
    logic       chan_b_ok;
    logic       synth_on;
    logic       free_run;
    logic       hold_high;
    logic [1:0] ext_lost_reg;

    assign sel_a     = ref_a_select_reg[4:0];
    assign sel_b     = ref_b_select_reg[4:0];
    assign synth_on  = !ref_clock_config_reg[ref_clock_pkg::BIT_SYNTH_BYP];
    assign free_run  = ref_clock_config_reg[ref_clock_pkg::BIT_FREE_RUN];
    assign hold_high = ref_clock_config_reg[ref_clock_pkg::BIT_HOLD_HIGH];

    // RQ11 external select range
    assign ext_a_sel = sel_a >= ref_clock_pkg::SEL_EXT_FIRST;
    assign ext_b_sel = sel_b >= ref_clock_pkg::SEL_EXT_FIRST;
    // RQ6 channel select
    assign chan_a_ok = sel_a < 5'(ref_clock_pkg::CHANNELS);
    assign chan_b_ok = sel_b < 5'(ref_clock_pkg::CHANNELS);

    logic rec_a;
    logic rec_b;
    logic e1_a;
    logic e1_b;
    logic loss_a;
    logic loss_b;

    always_comb begin
        rec_a  = 1'b0;
        rec_b  = 1'b0;
        loss_a = 1'b0;
        loss_b = 1'b0;
        // RQ12 rate bit trusted
        e1_a   = ref_a_select_reg[ref_clock_pkg::BIT_EXT_RATE];
        e1_b   = ref_b_select_reg[ref_clock_pkg::BIT_EXT_RATE];
        if (chan_a_ok) begin
            // RQ8 attenuator tap choice
            rec_a  = ref_clock_config_reg[ref_clock_pkg::BIT_TAP_SELECT] ?
                     raw_sync[sel_a] : filtered_sync[sel_a];
            // RQ7 rate from line mode
            e1_a   = channel_e1_mode[sel_a];
            loss_a = line_signal_loss[sel_a];
        end
        if (chan_b_ok) begin
            rec_b  = ref_clock_config_reg[ref_clock_pkg::BIT_TAP_SELECT] ?
                     raw_sync[sel_b] : filtered_sync[sel_b];
            e1_b   = channel_e1_mode[sel_b];
            loss_b = line_signal_loss[sel_b];
        end
    end

    // ********************
    // internal clock generator: five phase accumulators on clk
    // ********************
    // 0 T1 free, 1 E1 free, 2 synthesizer, 3 A fallback, 4 B fallback
    logic [31:0] nco_step_sel [5];
    logic [31:0] nco_acc_reg  [5];
    logic [4:0]  nco_level;

    always_comb begin
        // RQ1 T1 free rate
        nco_step_sel[0] = free_clock_gen_config_reg[ref_clock_pkg::BIT_T1_RATE] ?
                          ref_clock_pkg::STEP_T1 : ref_clock_pkg::STEP_8K;
        // RQ2 E1 free rate
        nco_step_sel[1] = free_clock_gen_config_reg[ref_clock_pkg::BIT_E1_RATE] ?
                          ref_clock_pkg::STEP_E1 : ref_clock_pkg::STEP_8K;
        // RQ9 synthesizer frequency codes
        case (ref_clock_config_reg[2:0])
            ref_clock_pkg::SYN_8K:     nco_step_sel[2] = ref_clock_pkg::STEP_8K;
            ref_clock_pkg::SYN_64K:    nco_step_sel[2] = ref_clock_pkg::STEP_64K;
            ref_clock_pkg::SYN_2048K:  nco_step_sel[2] = ref_clock_pkg::STEP_E1;
            ref_clock_pkg::SYN_4096K:  nco_step_sel[2] = ref_clock_pkg::STEP_4096K;
            ref_clock_pkg::SYN_8192K:  nco_step_sel[2] = ref_clock_pkg::STEP_8192K;
            ref_clock_pkg::SYN_19440K: nco_step_sel[2] = ref_clock_pkg::STEP_19440K;
            ref_clock_pkg::SYN_32768K: nco_step_sel[2] = ref_clock_pkg::STEP_32768K;
            default:                   nco_step_sel[2] = ref_clock_pkg::STEP_E1;
        endcase
        // RQ15 unchanged frequency fallback
        nco_step_sel[3] = e1_a ? ref_clock_pkg::STEP_E1 : ref_clock_pkg::STEP_T1;
        nco_step_sel[4] = e1_b ? ref_clock_pkg::STEP_E1 : ref_clock_pkg::STEP_T1;
    end

    // RQ3 generator locked to master
    // accumulators free-run from clk, which the analog loop locks to master
    for (genvar g = 0; g < 5; g++) begin : gen_nco
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                nco_acc_reg[g] <= 32'h0000_0000;
            end else begin
                nco_acc_reg[g] <= nco_acc_reg[g] + nco_step_sel[g];
            end
        end
        assign nco_level[g] = nco_acc_reg[g][31];
    end

    // ********************
    // external input loss watch
    // ********************
    localparam int LOSS_W_TOP = ref_clock_pkg::LOSS_CNT_W - 1;
    logic [1:0]            ext_prev_reg;
    logic [LOSS_W_TOP:0]   ext_idle_reg [2];
    logic [1:0]            ext_rate_e1;

    assign ext_rate_e1 = {ref_b_select_reg[ref_clock_pkg::BIT_EXT_RATE],
                          ref_a_select_reg[ref_clock_pkg::BIT_EXT_RATE]};

    // RQ16 eight silent periods
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_prev_reg <= 2'h0;
            ext_lost_reg <= 2'h0;
            ext_idle_reg[0] <= '0;
            ext_idle_reg[1] <= '0;
        end else begin
            ext_prev_reg <= ext_sync;
            for (int i = 0; i < 2; i++) begin
                if (ext_sync[i] != ext_prev_reg[i]) begin
                    ext_idle_reg[i] <= '0;
                    ext_lost_reg[i] <= 1'b0;
                end else if (ext_idle_reg[i] >= (ext_rate_e1[i] ?
                             ref_clock_pkg::LOSS_CYCLES_E1 :
                             ref_clock_pkg::LOSS_CYCLES_T1)) begin
                    ext_lost_reg[i] <= 1'b1;
                end else begin
                    ext_idle_reg[i] <= ext_idle_reg[i] + 1'b1;
                end
            end
        end
    end

    // ********************
    // output target levels
    // ********************
    logic level_a;
    logic level_b;

    always_comb begin
        level_a = 1'b0;
        // RQ10 free-run synthesizer
        // RQ14 reserved codes
        if (synth_on && free_run) begin
            level_a = nco_level[2];
        end else if (ext_a_sel) begin
            // RQ13 external pass-through
            level_a = ext_lost_reg[0] ? 1'b1 :
                      (synth_on ? nco_level[2] : ext_sync[0]);
        end else if (chan_a_ok) begin
            // RQ15 line loss handling
            if (loss_a) begin
                level_a = hold_high ? 1'b1 : (synth_on ? nco_level[2] : nco_level[3]);
            end else begin
                level_a = synth_on ? nco_level[2] : rec_a;
            end
        end
    end

    always_comb begin
        level_b = 1'b0;
        if (ext_b_sel) begin
            // RQ16 loss action
            level_b = ext_lost_reg[1] ? (hold_high | nco_level[4]) : ext_sync[1];
        end else if (chan_b_ok) begin
            level_b = loss_b ? (hold_high | nco_level[4]) : rec_b;
        end
    end

    // ********************
    // output switching held after a setting change until output and target are low, one slice per output pin
    // ********************
    // 0 T1 free, 1 E1 free, 2 reference A, 3 reference B
    logic [3:0]  target;
    logic [3:0]  enable;
    logic [15:0] setting [4];
    logic [15:0] setting_prev_reg [4];
    logic [3:0]  pending_reg;
    logic [3:0]  out_reg;
    logic [3:0]  oe_reg;

    assign target = {level_b, level_a, nco_level[1], nco_level[0]};
    assign enable = {ref_b_select_reg[ref_clock_pkg::BIT_REF_EN],
                     ref_a_select_reg[ref_clock_pkg::BIT_REF_EN],
                     free_clock_gen_config_reg[ref_clock_pkg::BIT_E1_EN],
                     free_clock_gen_config_reg[ref_clock_pkg::BIT_T1_EN]};
    assign setting[0] = {8'h00, free_clock_gen_config_reg[1:0] , 6'h00};
    assign setting[1] = {8'h00, free_clock_gen_config_reg[3:2] , 6'h00};
    assign setting[2] = {ref_clock_config_reg[6:0], 2'h0, ref_a_select_reg[6:0]};
    assign setting[3] = {ref_clock_config_reg[6], 8'h00, ref_b_select_reg[6:0]};

    for (genvar s = 0; s < 4; s++) begin : gen_switch
        // RQ17 hold until both low
        // a high phase may be stretched or cut short when a setting word changes; loss switches are not held
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                setting_prev_reg[s] <= 16'h0000;
                pending_reg[s]      <= 1'b0;
                out_reg[s]          <= 1'b0;
            end else begin
                setting_prev_reg[s] <= setting[s];
                if (setting[s] != setting_prev_reg[s]) begin
                    pending_reg[s] <= 1'b1;
                end else if (pending_reg[s] && !out_reg[s] && !target[s]) begin
                    pending_reg[s] <= 1'b0;
                end
                if (pending_reg[s] || setting[s] != setting_prev_reg[s]) begin
                    if (out_reg[s] && !target[s]) begin
                        out_reg[s] <= 1'b0;
                    end
                end else begin
                    out_reg[s] <= target[s];
                end
                // RQ5 parked low when off
                if (!enable[s]) begin
                    out_reg[s] <= 1'b0;
                end
            end
        end

        // RQ5 output enables
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                oe_reg[s] <= 1'b0;
            end else begin
                oe_reg[s] <= enable[s];
            end
        end
    end

    assign t1_free_clock_out  = out_reg[0];
    assign t1_free_clock_oe   = oe_reg[0];
    assign e1_free_clock_out  = out_reg[1];
    assign e1_free_clock_oe   = oe_reg[1];
    assign ref_clock_out_a    = out_reg[2];
    assign ref_clock_out_a_oe = oe_reg[2];
    assign ref_clock_out_b    = out_reg[3];
    assign ref_clock_out_b_oe = oe_reg[3];

    // ********************
    // register read port, data valid only in the cycle after the strobe
    // ********************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ref_clock_pkg::ADDR_GEN_CFG: reg_rdata <= free_clock_gen_config_reg;
                ref_clock_pkg::ADDR_REF_A:   reg_rdata <= ref_a_select_reg;
                ref_clock_pkg::ADDR_REF_B:   reg_rdata <= ref_b_select_reg;
                ref_clock_pkg::ADDR_REF_CFG: reg_rdata <= ref_clock_config_reg;
                ref_clock_pkg::ADDR_STATUS:
                    reg_rdata <= {4'h0, loss_b & chan_b_ok, loss_a & chan_a_ok,
                                  ext_lost_reg};
                ref_clock_pkg::ADDR_STRAPS:
                    reg_rdata <= {4'h0, generator_e1_family, generator_multiplier};
                default:                     reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// [ref_clock_output_select_monitor.sv]
// port checker for the reference clock output selection block
`timescale 1ns/100ps
module ref_clock_output_select_monitor (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       t1_free_clock_out,
    input wire logic       t1_free_clock_oe,
    input wire logic       e1_free_clock_oe,
    input wire logic       ref_clock_out_a,
    input wire logic       ref_clock_out_a_oe,
    input wire logic       ref_clock_out_b_oe,
    input wire logic [2:0] generator_multiplier
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ********************
    // enables land two cycles after the write that sets them
    // ********************
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    AST_T1_OE: assert property (s_wr(3'h0) |-> ##2 t1_free_clock_oe == $past(reg_wdata[1], 2))
        else $error("t1 enable wrong");
    AST_E1_OE: assert property (s_wr(3'h0) |-> ##2 e1_free_clock_oe == $past(reg_wdata[3], 2))
        else $error("e1 enable wrong");
    AST_A_OE: assert property (s_wr(3'h1) |-> ##2 ref_clock_out_a_oe == $past(reg_wdata[6], 2))
        else $error("ref a enable wrong");
    AST_B_OE: assert property (s_wr(3'h2) |-> ##2 ref_clock_out_b_oe == $past(reg_wdata[6], 2))
        else $error("ref b enable wrong");
    AST_T1_HIZ: assert property (!t1_free_clock_oe |-> !t1_free_clock_out)
        else $error("t1 driven while off");
    AST_A_HIZ: assert property (!ref_clock_out_a_oe |-> !ref_clock_out_a)
        else $error("ref a driven while off");
    AST_STRAP_RD: assert property (reg_rd && reg_addr == 3'h5 |=>
        reg_rdata[2:0] == generator_multiplier) else $error("strap read wrong");
    AST_STRAP_HOLD: assert property (generator_multiplier != 3'h0 |=> $stable(generator_multiplier))
        else $error("multiplier moved");
endmodule
bind ref_clock_output_select ref_clock_output_select_monitor ref_clock_output_select_monitor_inst (.*);

// [clock_source_model.sv]
// line clocks and external clock sources beside the block
`timescale 1ns/100ps
module clock_source_model (
    input  wire logic        stop_a,
    output logic      [16:0] raw,
    output logic      [16:0] filt,
    output logic             ext_a,
    output logic             ext_b
);
    logic r = 1'b0;
    logic f = 1'b0;
    // only channel 3 carries a clock, so a wrong pick stays flat
    assign raw  = {13'h0000, r, 3'h0};
    assign filt = {13'h0000, f, 3'h0};
    always #324 r = ~r;
    always #244 f = ~f;
    initial ext_a = 1'b0;
    initial ext_b = 1'b0;
    // a lost clock just stops where it was
    always #324 if (!stop_a) ext_a = ~ext_a;
    always #244 ext_b = ~ext_b;
endmodule

// [ref_clock_output_select_bench.sv]
// testbench for the reference clock output selection block
`timescale 1ns/100ps
module ref_clock_output_select_bench;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        stop_a = 1'b0;
    logic [16:0] loss = 17'h0_0000;
    logic [16:0] raw, filt;
    logic        ext_a, ext_b, fam;
    logic [7:0]  rdata;
    logic [3:0]  outs, oes;
    logic [2:0]  mult;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          khz[5] = '{2048, 4096, 8192, 19440, 32768};
    logic [2:0]  code[5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    clock_source_model clock_source_model_inst (.stop_a(stop_a), .raw(raw), .filt(filt),
        .ext_a(ext_a), .ext_b(ext_b));
    ref_clock_output_select ref_clock_output_select_inst (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .master_rate_straps(4'hd), .recovered_clock_raw(raw),
        .recovered_clock_filtered(filt), .channel_e1_mode(17'h0_0008),
        .line_signal_loss(loss), .external_clock_in_a(ext_a), .external_clock_in_b(ext_b),
        .t1_free_clock_out(outs[0]), .t1_free_clock_oe(oes[0]), .e1_free_clock_out(outs[1]),
        .e1_free_clock_oe(oes[1]), .ref_clock_out_a(outs[2]), .ref_clock_out_a_oe(oes[2]),
        .ref_clock_out_b(outs[3]), .ref_clock_out_b_oe(oes[3]),
        .generator_multiplier(mult), .generator_e1_family(fam));
    initial forever #4 clk = ~clk;
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] exp, string nm);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(nm, 32'(rdata), 32'(exp));
    endtask
    // counts rising edges of one output; window and bounds set the rate
    task automatic meas(int i, int n, int lo, int hi, string nm);
        int   e = 0;
        logic p;
        p = outs[i];
        repeat (n) begin
            @(posedge clk);
            #1 e += 32'(outs[i] & !p);
            p = outs[i];
        end
        check(nm, 32'(e >= lo && e <= hi), 32'h0000_0001);
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check("multiplier", 32'(mult), 32'h0000_0005);
        rd(3'h5, 8'h0d, "strap reg");
        rd(3'h0, 8'h00, "gen reset");
        rd(3'h3, 8'h10, "cfg reset");
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00, "unmapped");
        wr(3'h0, 8'h0f);
        meas(0, 2500, 29, 32, "t1 line");
        meas(1, 2500, 39, 42, "e1 line");
        wr(3'h0, 8'h0a);
        meas(0, 16000, 1, 2, "t1 8k");
        meas(1, 16000, 1, 2, "e1 8k");
        wr(3'h0, 8'h00);
        repeat (2) @(posedge clk);
        #1 check("free oe", 32'(oes[1:0]), 32'h0000_0000);
        wr(3'h1, 8'h43);
        meas(2, 2500, 39, 42, "a filtered");
        wr(3'h3, 8'h50);
        meas(2, 2500, 29, 32, "a raw");
        wr(3'h1, 8'h42);
        meas(2, 1000, 0, 0, "a flat channel");
        wr(3'h2, 8'h43);
        meas(3, 2500, 29, 32, "b raw");
        wr(3'h1, 8'h5f);
        meas(2, 2500, 29, 32, "a external");
        wr(3'h2, 8'h7d);
        meas(3, 2500, 39, 42, "b external");
        for (int k = 0; k < 5; k++) begin
            wr(3'h3, {5'h01, code[k]});
            meas(2, 1000, khz[k] / 125 - 2, khz[k] / 125 + 2, "synth free");
        end
        wr(3'h3, 8'h03);
        meas(2, 16000, 6, 10, "synth 64k");
        wr(3'h3, 8'h30);
        @(posedge clk);
        stop_a <= 1'b1;
        repeat (700) @(posedge clk);
        #1 check("a lost", 32'(outs[2]), 32'h0000_0001);
        rd(3'h4, 8'h01, "status a lost");
        wr(3'h2, 8'h43);
        loss <= 17'h0_0008;
        repeat (20) @(posedge clk);
        meas(3, 500, 0, 0, "b held");
        check("b high", 32'(outs[3]), 32'h0000_0001);
        rd(3'h4, 8'h09, "status line");
        test_done;
    end
endmodule
